// File: bench/tcdma_ctrl_properties.sv
// Port checks of the DMA bus control
`timescale 1ns/10ps
module tcdma_ctrl_properties (
    // Inputs
    input wire logic clk,
    input wire logic rstn,
    input wire logic bus_request_n,
    input wire logic nmi_n,
    input wire logic cpu_irq_enable_flag,
    // Outputs
    input wire logic mem_request_n,
    input wire logic io_request_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic bus_grant_n,
    input wire logic chan1_xfer_done_n,
    input wire logic term_irq_request,
    input wire logic term_irq_take,
    input wire logic [7:0] xfer_status_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_one_strobe: assert property (
        (!rd_n || !wr_n) |-> (mem_request_n != io_request_n))
        else $error("strobe mix");
    a_io_wait: assert property (
        $fell(io_request_n) |-> (!io_request_n)[*3])
        else $error("io wait short");
    a_grant_quiet: assert property (
        !bus_grant_n |-> mem_request_n && io_request_n)
        else $error("strobe in hold");
    a_grant_drop: assert property (
        bus_request_n [*5] |-> bus_grant_n)
        else $error("grant held");
    a_done_write: assert property (
        $fell(chan1_xfer_done_n) |-> !wr_n && !io_request_n)
        else $error("done misplaced");
    a_irq_level: assert property (
        term_irq_request == ((!xfer_status_reg[7] && xfer_status_reg[3])
        || (!xfer_status_reg[6] && xfer_status_reg[2]))
        && term_irq_take == (term_irq_request && cpu_irq_enable_flag))
        else $error("irq level");
    a_nmi_stop: assert property (
        $fell(nmi_n) |-> ##[1:5] !xfer_status_reg[0])
        else $error("nmi kept master");
    a_master_off: assert property (
        (!xfer_status_reg[0]) [*8] |-> mem_request_n && io_request_n)
        else $error("xfer master off");
    c_hold: cover property (!bus_grant_n);
    c_done: cover property ($rose(chan1_xfer_done_n));
    c_nmi: cover property ($fell(nmi_n) ##3 !xfer_status_reg[0]);
endmodule : tcdma_ctrl_properties
bind tcdma_ctrl tcdma_ctrl_properties u_props (.clk(clk), .rstn(rstn),
    .bus_request_n(bus_request_n), .nmi_n(nmi_n),
    .cpu_irq_enable_flag(cpu_irq_enable_flag),
    .mem_request_n(mem_request_n), .io_request_n(io_request_n),
    .rd_n(rd_n), .wr_n(wr_n), .bus_grant_n(bus_grant_n),
    .chan1_xfer_done_n(chan1_xfer_done_n),
    .term_irq_request(term_irq_request), .term_irq_take(term_irq_take),
    .xfer_status_reg(xfer_status_reg));

// File: bench/tcdma_io_dev.sv
// External I/O device model for channel 1
`timescale 1ns/10ps
module tcdma_io_dev (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bench control
    input wire logic want,
    input wire logic slow,
    // Pins
    output logic request_n,
    input wire logic done_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic io_request_n,
    output logic [7:0] rdata,
    output logic [7:0] last_rd
);
    logic [1:0] stall;
    // Slow device pauses after each byte
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            request_n <= 1'b1;
            stall <= 2'h0;
        end
        else if (!io_request_n && !wr_n && slow && stall == 2'h0)
        begin
            request_n <= 1'b1;
            stall <= 2'h3;
        end
        else
        begin
            stall <= (stall == 2'h0) ? 2'h0 : stall - 2'h1;
            request_n <= !(want && done_n && stall == 2'h0);
        end
    end
    // Data churns while released
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= 8'h5a;
        else if (rd_n)
            rdata <= rdata + 8'h37;
        else
            last_rd <= rdata;
    end
endmodule : tcdma_io_dev

// File: bench/two_channel_dma_bus_control_test.sv
// Bench of the DMA bus control
`timescale 1ns/10ps
`include "tcdma_defines.svh"
module two_channel_dma_bus_control_test;
    logic clk = 1'b0, rstn = 1'b0, status_wr = 1'b0, ctrl_wr = 1'b0;
    logic mode_wr = 1'b0, addr_load = 1'b0, count_load = 1'b0;
    logic count_sel = 1'b0, flag = 1'b0, breq_n = 1'b1, nmi_n = 1'b1;
    logic want = 1'b0, slow = 1'b0, chk_order = 1'b0;
    logic [7:0] wd = 8'h00, st, ctl, md, rdata, last_rd, dout;
    logic [1:0] addr_sel = 2'h0, wgen = 2'h0;
    logic [19:0] addr_data = 20'h0, io_addr = 20'h0, baddr;
    logic [15:0] count_data = 16'h0;
    logic mem_request_n_n, ioreq_n, rd_n, wr_n, grant_n, d0_n, d1_n, req1_n;
    logic irq, take, io_prev = 1'b1, mem_prev = 1'b1;
    int failures = 0, n_compared = 0, cycles = 0, io_wr = 0, mem_wr = 0;
    int n, b;
    tcdma_ctrl uut (.clk(clk), .rstn(rstn), .status_wr(status_wr),
        .status_wdata(wd), .ctrl_wr(ctrl_wr), .ctrl_wdata(wd),
        .mode_wr(mode_wr), .mode_wdata(wd), .xfer_status_reg(st),
        .xfer_control_reg(ctl), .xfer_mode_reg(md), .addr_load(addr_load),
        .addr_sel(addr_sel), .addr_data(addr_data), .count_load(count_load),
        .count_sel(count_sel), .count_data(count_data),
        .wait_gen_count(wgen), .cpu_irq_enable_flag(flag),
        .term_irq_request(irq), .term_irq_take(take),
        .chan0_xfer_request_n(1'b1), .chan1_xfer_request_n(req1_n),
        .chan0_xfer_done_n(d0_n), .chan1_xfer_done_n(d1_n),
        .bus_request_n(breq_n), .bus_grant_n(grant_n), .wait_n(1'b1),
        .nmi_n(nmi_n), .mem_request_n(mem_request_n_n), .io_request_n(ioreq_n),
        .rd_n(rd_n), .wr_n(wr_n), .bus_addr(baddr), .bus_data_in(rdata),
        .bus_data_out(dout));
    tcdma_io_dev dev (.clk(clk), .rstn(rstn), .want(want), .slow(slow),
        .request_n(req1_n), .done_n(d1_n), .rd_n(rd_n), .wr_n(wr_n),
        .io_request_n(ioreq_n), .rdata(rdata), .last_rd(last_rd));
    initial forever #5 clk = ~clk;
    function automatic logic [7:0] exp_st(input logic [7:0] f);
        return f | `TCDMA_ST_READ_ONES;
    endfunction : exp_st
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // Strobe checks
    always @(posedge clk)
    begin
        io_prev <= ioreq_n;
        mem_prev <= mem_request_n_n;
        cycles <= cycles + 1;
        if (io_prev && !ioreq_n && !wr_n)
        begin
            io_wr <= io_wr + 1;
            check(dout, last_rd);
            check(baddr[15:0], io_addr[15:0]);
            if (chk_order)
                check(st[6], 1'b0);
        end
        if (mem_prev && !mem_request_n_n && !wr_n)
            mem_wr <= mem_wr + 1;
        if (cycles == 40000)
        begin
            failures++;
            stop_test();
        end
    end
    // 0 status, 1 control, 2 mode
    task automatic wr(input int which, input logic [7:0] d);
        @(negedge clk);
        {status_wr, ctrl_wr, mode_wr} = 3'b100 >> which;
        wd = d;
        @(negedge clk);
        {status_wr, ctrl_wr, mode_wr} = 3'b000;
    endtask : wr
    task automatic load(input logic [1:0] s, input logic [19:0] a,
        input logic cs, input logic [15:0] c);
        @(negedge clk);
        {addr_load, addr_sel, addr_data} = {1'b1, s, a};
        {count_load, count_sel, count_data} = {1'b1, cs, c};
        @(negedge clk);
        {addr_load, count_load} = 2'b00;
    endtask : load
    // 0 io strobe, 1 grant, 6/7 enable clear
    task automatic wait_for(input int w);
        for (int k = 0; k < 600; k++)
        begin
            if (w == 0 ? !ioreq_n : w == 1 ? !grant_n : st[w] === 1'b0)
                break;
            @(negedge clk);
        end
    endtask : wait_for
    task automatic ch1_setup(input int cnt, input logic [7:0] c);
        io_addr = 20'($urandom_range(0, 16'hffff));
        load(2'h3, io_addr, 1'b1, 16'(cnt));
        load(2'h2, 20'($urandom), 1'b1, 16'(cnt));
        wr(1, c);
        check(ctl, c);
        b = io_wr;
    endtask : ch1_setup
    initial
    begin
        void'($urandom(68215));
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        check(st, exp_st(8'h00));
        check({ctl, md, mem_request_n_n, ioreq_n, grant_n, d1_n}, 20'hf);
        $display("reset done");
        for (int i = 0; i < 3; i++)
        begin
            n = $urandom_range(1, 4);
            wgen = 2'($urandom);
            ch1_setup(n, (i == 2) ? 8'h0a : 8'h02);
            wr(0, 8'ha9);
            check(st[7], 1'b0);
            wr(0, 8'h89);
            {want, slow} = {1'b1, i > 0};
            flag = 1'($urandom);
            wait_for(7);
            check(st[7], 1'b0);
            check(20'(io_wr - b), 20'(n));
            check({irq, take, d1_n}, {1'b1, flag, 1'b1});
            wr(0, 8'h01);
            check(irq, 1'b0);
            want = 1'b0;
        end
        $display("ch1 done");
        ch1_setup(4, 8'h02);
        {want, slow} = 2'b10;
        wr(0, 8'h81);
        wait_for(0);
        repeat ($urandom_range(0, 6)) @(negedge clk);
        breq_n = 1'b0;
        wait_for(1);
        check(grant_n, 1'b0);
        repeat (8) @(negedge clk);
        breq_n = 1'b1;
        wait_for(7);
        check(20'(io_wr - b), 20'h4);
        $display("hold done");
        ch1_setup(4, 8'h02);
        wr(0, 8'h81);
        wait_for(0);
        nmi_n = 1'b0;
        repeat (12) @(negedge clk);
        nmi_n = 1'b1;
        check({st[7], st[0]}, 2'b10);
        n = io_wr;
        repeat (30) @(negedge clk);
        check(20'(io_wr), 20'(n));
        wr(0, 8'h81);
        wait_for(7);
        check(20'(io_wr - b), 20'h4);
        want = 1'b0;
        $display("nmi done");
        n = $urandom_range(1, 5);
        wr(2, {6'h0, 1'($urandom), 1'b0});
        check(md[7:2], 6'h0);
        load(2'h0, 20'h0fffe, 1'b0, 16'(n));
        load(2'h1, 20'($urandom), 1'b0, 16'(n));
        ch1_setup(2, 8'h02);
        n = n + mem_wr;
        {want, chk_order} = 2'b11;
        wr(0, 8'hc1);
        wait_for(6);
        check(20'(mem_wr), 20'(n));
        wait_for(7);
        check(20'(io_wr - b), 20'h2);
        {want, chk_order} = 2'b00;
        $display("prio done");
        stop_test();
    end
endmodule : two_channel_dma_bus_control_test

// File: hdl/tcdma_ctrl.sv
// Two-channel byte DMA bus control: sequencing, strobes, arbitration
`timescale 1ns/10ps
`include "tcdma_defines.svh"

// Functional notes
// - Control bit picks level or edge sensing for channel 1 request.
// - Per-channel interrupt enable gates channel 1 termination interrupt.
// - Channel enable written 1 only when its write guard is 0.
// - Memory access drives mem_request_n low; I/O access drives io_request_n.
// - I/O transfers are paced by request input; done output marks end.
// - I/O accesses get one automatic wait, plus generator and wait pin.
// - Memory-mapped I/O accesses get no automatic wait state.
// - Memory-to-memory on channel 0 ignores request; burst or cycle steal.
// - Address carry or borrow across A15/A16 adds one idle state.
// - Simultaneous requests: channel 0 wins over channel 1.
// - Channel 1 held off while channel 0 memory-to-memory is enabled.
// - Channel 0 waits while channel 1 owns the bus.
// - External bus request suspends DMA at next access boundary.
// - Released bus resumes suspended transfer, pending write included.
// - Count reaching zero clears channel enable until software sets it.
// - Termination interrupt is level: enable clear and interrupt enable set.
// - Non-maskable interrupt clears master enable, suspending both channels.
// - Non-maskable interrupt suspends DMA after the current access.
// - Setting master enable after suspension resumes from suspended point.
// - Reset inits status, mode, control; keeps addresses and counts.
// - Level sense samples request in the state before T3.
// - Edge sense starts transfer on request falling edge.
// - Done output low during write of final transfer.
module tcdma_ctrl #(
    parameter int ADDR_W = 20,
    parameter int COUNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Software register writes and reads
    input wire logic status_wr,
    input wire logic [7:0] status_wdata,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    output logic [7:0] xfer_status_reg,
    output logic [7:0] xfer_control_reg,
    output logic [7:0] xfer_mode_reg,
    // Address and count loading
    input wire logic addr_load,
    input wire logic [1:0] addr_sel,
    input wire logic [ADDR_W-1:0] addr_data,
    input wire logic count_load,
    input wire logic count_sel,
    input wire logic [COUNT_W-1:0] count_data,
    // Processor side
    input wire logic [1:0] wait_gen_count,
    input wire logic cpu_irq_enable_flag,
    output logic term_irq_request,
    output logic term_irq_take,
    // Pins
    input wire logic chan0_xfer_request_n,
    input wire logic chan1_xfer_request_n,
    output logic chan0_xfer_done_n,
    output logic chan1_xfer_done_n,
    input wire logic bus_request_n,
    output logic bus_grant_n,
    input wire logic wait_n,
    input wire logic nmi_n,
    // Bus
    output logic mem_request_n,
    output logic io_request_n,
    output logic rd_n,
    output logic wr_n,
    output logic [ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out
);

    localparam int CPU_SLOT = (`TCDMA_CPU_SLOT_NS + `TCDMA_CLK_NS - 1)
        / `TCDMA_CLK_NS;
    localparam logic [2:0] CPU_SLOT_CNT = 3'(CPU_SLOT);

    tcdma_pkg::tcdma_state_t state;
    logic [ADDR_W-1:0] addr_mem [4];
    logic [COUNT_W-1:0] count_mem [2];
    logic [1:0] chan_enable;
    logic [1:0] chan_irq_enable;
    logic master_xfer_enable;
    logic owner;
    logic is_write;
    logic pend_write;
    logic cross_pend;
    logic [2:0] wait_cnt;
    logic [2:0] slot_cnt;
    logic [1:0] edge_pend;
    logic [1:0] req_cap;
    logic [1:0] just_done;
    logic [1:0] done_n;
    logic [7:0] data_latch;
    logic [4:0] sync_q;
    logic [1:0] req_prev;
    logic nmi_prev;

    logic [1:0] req_n_s;
    logic bus_req_s;
    logic wait_s;
    logic nmi_s;
    logic [1:0] cur_slot;
    logic [1:0] cur_mode;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] next_addr;
    logic mm_mode;
    logic [1:0] req_ok;
    logic start0;
    logic start1;
    logic last_byte;
    logic in_access;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    tcdma_sync #(
        .WIDTH(5),
        .INIT(5'h1f)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in({nmi_n, wait_n, bus_request_n, chan1_xfer_request_n,
            chan0_xfer_request_n}),
        .sync_out(sync_q)
    );

    assign req_n_s = sync_q[1:0];
    assign bus_req_s = ~sync_q[2];
    assign wait_s = ~sync_q[3];
    assign nmi_s = ~sync_q[4];

    ////////////////////////////////////////////////////////////////////////
    // Address slot and mode decoding
    function automatic logic [1:0] slot_of(input logic own,
        input logic wr, input logic c1_mem_to_io);
        if (!own)
            slot_of = wr ? `TCDMA_SLOT_DST0 : `TCDMA_SLOT_SRC0;
        else
            slot_of = (wr ^ c1_mem_to_io) ? `TCDMA_SLOT_MEM1
                : `TCDMA_SLOT_IO1;
    endfunction : slot_of

    function automatic logic [1:0] mode_of(input logic [1:0] slot,
        input logic [7:0] md, input logic [7:0] ct);
        unique case (slot)
            `TCDMA_SLOT_SRC0: mode_of = md[`TCDMA_MD_SRC_HI:`TCDMA_MD_SRC_LO];
            `TCDMA_SLOT_DST0: mode_of = md[`TCDMA_MD_DST_HI:`TCDMA_MD_DST_LO];
            `TCDMA_SLOT_MEM1: mode_of = ct[`TCDMA_CT_C1_MEM_DEC]
                ? tcdma_pkg::AM_MEM_DEC : tcdma_pkg::AM_MEM_INC;
            `TCDMA_SLOT_IO1: mode_of = tcdma_pkg::AM_IO_FIXED;
        endcase
    endfunction : mode_of

    function automatic logic is_step_mode(input logic [1:0] m);
        is_step_mode = (m == tcdma_pkg::AM_MEM_INC)
            || (m == tcdma_pkg::AM_MEM_DEC);
    endfunction : is_step_mode

    assign cur_slot = slot_of(owner, is_write,
        xfer_control_reg[`TCDMA_CT_C1_MEM_TO_IO]);
    assign cur_mode = mode_of(cur_slot, xfer_mode_reg, xfer_control_reg);
    assign cur_addr = addr_mem[cur_slot];
    assign next_addr = (cur_mode == tcdma_pkg::AM_MEM_INC) ? cur_addr + 1'b1
        : (cur_mode == tcdma_pkg::AM_MEM_DEC) ? cur_addr - 1'b1 : cur_addr;
    assign mm_mode = is_step_mode(mode_of(`TCDMA_SLOT_SRC0, xfer_mode_reg,
        xfer_control_reg)) && is_step_mode(mode_of(`TCDMA_SLOT_DST0,
        xfer_mode_reg, xfer_control_reg));
    assign last_byte = count_mem[owner] == COUNT_W'(`TCDMA_LAST_COUNT);
    assign in_access = (state == tcdma_pkg::S_T1)
        || (state == tcdma_pkg::S_T2) || (state == tcdma_pkg::S_TW)
        || (state == tcdma_pkg::S_T3);

    ////////////////////////////////////////////////////////////////////////
    // Request pacing
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_req
            logic sense_edge;
            assign sense_edge = xfer_control_reg[ch == 0
                ? `TCDMA_CT_SENSE0 : `TCDMA_CT_SENSE1];
            assign req_ok[ch] = sense_edge ? edge_pend[ch]
                : (just_done[ch] ? req_cap[ch] : ~req_n_s[ch]);
        end
    endgenerate

    assign start0 = chan_enable[0] && (mm_mode
        ? (slot_cnt == 3'h0) : req_ok[0]);
    assign start1 = chan_enable[1] && req_ok[1]
        && !(chan_enable[0] && mm_mode);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            req_prev <= 2'h3;
            edge_pend <= 2'h0;
            req_cap <= 2'h0;
            just_done <= 2'h0;
        end
        else
        begin
            req_prev <= req_n_s;
            for (int ch = 0; ch < 2; ch++)
            begin
                if (req_prev[ch] && !req_n_s[ch])
                    edge_pend[ch] <= 1'b1;
                else if (state == tcdma_pkg::S_T1 && !is_write
                    && owner == ch[0])
                    edge_pend[ch] <= 1'b0;
                if (is_write && owner == ch[0]
                    && (state == tcdma_pkg::S_T2 || state == tcdma_pkg::S_TW))
                    req_cap[ch] <= ~req_n_s[ch];
                just_done[ch] <= state == tcdma_pkg::S_T3 && is_write
                    && owner == ch[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= tcdma_pkg::S_IDLE;
            owner <= 1'b0;
            is_write <= 1'b0;
            pend_write <= 1'b0;
            cross_pend <= 1'b0;
            wait_cnt <= 3'h0;
            slot_cnt <= 3'h0;
        end
        else
        begin
            unique case (state)
                tcdma_pkg::S_IDLE:
                begin
                    if (slot_cnt != 3'h0)
                        slot_cnt <= slot_cnt - 3'h1;
                    if (bus_req_s)
                        state <= tcdma_pkg::S_HOLD;
                    else if (!master_xfer_enable)
                        state <= tcdma_pkg::S_IDLE;
                    else if (pend_write)
                    begin
                        if (chan_enable[owner])
                            state <= tcdma_pkg::S_T1;
                    end
                    else if (start0)
                    begin
                        owner <= 1'b0;
                        state <= tcdma_pkg::S_T1;
                    end
                    else if (start1)
                    begin
                        owner <= 1'b1;
                        state <= tcdma_pkg::S_T1;
                    end
                end
                tcdma_pkg::S_T1:
                begin
                    wait_cnt <= 3'(wait_gen_count)
                        + ((cur_mode == tcdma_pkg::AM_IO_FIXED)
                        ? `TCDMA_AUTO_IO_WAITS : 3'h0);
                    state <= tcdma_pkg::S_T2;
                end
                tcdma_pkg::S_T2, tcdma_pkg::S_TW:
                begin
                    if (wait_cnt != 3'h0)
                    begin
                        wait_cnt <= wait_cnt - 3'h1;
                        state <= tcdma_pkg::S_TW;
                    end
                    else if (wait_s)
                        state <= tcdma_pkg::S_TW;
                    else
                        state <= tcdma_pkg::S_T3;
                end
                tcdma_pkg::S_T3:
                begin
                    cross_pend <= 1'b0;
                    is_write <= ~is_write;
                    pend_write <= ~is_write;
                    if (is_write && owner == 1'b0 && mm_mode
                        && !xfer_mode_reg[`TCDMA_MD_BURST])
                        slot_cnt <= CPU_SLOT_CNT;
                    if (next_addr[ADDR_W-1:16] != cur_addr[ADDR_W-1:16])
                    begin
                        cross_pend <= !is_write;
                        state <= tcdma_pkg::S_TI;
                    end
                    else if (is_write)
                        state <= tcdma_pkg::S_IDLE;
                    else if (bus_req_s)
                        state <= tcdma_pkg::S_HOLD;
                    else if (!master_xfer_enable)
                        state <= tcdma_pkg::S_IDLE;
                    else
                        state <= tcdma_pkg::S_T1;
                end
                tcdma_pkg::S_TI:
                begin
                    cross_pend <= 1'b0;
                    if (!cross_pend)
                        state <= tcdma_pkg::S_IDLE;
                    else if (bus_req_s)
                        state <= tcdma_pkg::S_HOLD;
                    else if (!master_xfer_enable)
                        state <= tcdma_pkg::S_IDLE;
                    else
                        state <= tcdma_pkg::S_T1;
                end
                tcdma_pkg::S_HOLD:
                begin
                    if (!bus_req_s)
                        state <= tcdma_pkg::S_IDLE;
                end
                default:
                    state <= tcdma_pkg::S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Addresses and counts: loaded by software, never touched by reset
    always_ff @(posedge clk)
    begin
        if (addr_load)
            addr_mem[addr_sel] <= addr_data;
        else if (state == tcdma_pkg::S_T3)
            addr_mem[cur_slot] <= next_addr;
        if (count_load)
            count_mem[count_sel] <= count_data;
        else if (state == tcdma_pkg::S_T3 && is_write)
            count_mem[owner] <= count_mem[owner] - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status, control and mode registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            chan_enable <= 2'h0;
            chan_irq_enable <= 2'h0;
            master_xfer_enable <= 1'b0;
            nmi_prev <= 1'b0;
        end
        else
        begin
            nmi_prev <= nmi_s;
            if (state == tcdma_pkg::S_T3 && is_write && last_byte)
                chan_enable[owner] <= 1'b0;
            if (status_wr)
            begin
                if (!status_wdata[`TCDMA_ST_GUARD0])
                    chan_enable[0] <= status_wdata[`TCDMA_ST_EN0];
                if (!status_wdata[`TCDMA_ST_GUARD1])
                    chan_enable[1] <= status_wdata[`TCDMA_ST_EN1];
                chan_irq_enable[0] <= status_wdata[`TCDMA_ST_IE0];
                chan_irq_enable[1] <= status_wdata[`TCDMA_ST_IE1];
            end
            if (nmi_s && !nmi_prev)
                master_xfer_enable <= 1'b0;
            else if (status_wr)
                master_xfer_enable <= status_wdata[`TCDMA_ST_MASTER];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            xfer_control_reg <= `TCDMA_CT_RESET;
            xfer_mode_reg <= `TCDMA_MD_RESET;
        end
        else
        begin
            if (ctrl_wr)
                xfer_control_reg <= ctrl_wdata;
            if (mode_wr)
                xfer_mode_reg <= mode_wdata;
        end
    end

    always_comb
    begin
        xfer_status_reg = `TCDMA_ST_READ_ONES;
        xfer_status_reg[`TCDMA_ST_EN1] = chan_enable[1];
        xfer_status_reg[`TCDMA_ST_EN0] = chan_enable[0];
        xfer_status_reg[`TCDMA_ST_IE1] = chan_irq_enable[1];
        xfer_status_reg[`TCDMA_ST_IE0] = chan_irq_enable[0];
        xfer_status_reg[`TCDMA_ST_MASTER] = master_xfer_enable;
    end

    assign term_irq_request = |(~chan_enable & chan_irq_enable);
    assign term_irq_take = term_irq_request && cpu_irq_enable_flag;

    ////////////////////////////////////////////////////////////////////////
    // Bus outputs
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_addr <= '0;
            data_latch <= 8'h00;
            done_n <= 2'h3;
            bus_grant_n <= 1'b1;
        end
        else
        begin
            bus_grant_n <= state != tcdma_pkg::S_HOLD;
            if (state == tcdma_pkg::S_T1)
                bus_addr <= cur_addr;
            if (state == tcdma_pkg::S_T3 && !is_write)
                data_latch <= bus_data_in;
            if (state == tcdma_pkg::S_T1 && is_write && last_byte)
                done_n[owner] <= 1'b0;
            else if (state == tcdma_pkg::S_T3)
                done_n <= 2'h3;
        end
    end

    assign bus_data_out = data_latch;
    assign chan0_xfer_done_n = done_n[0];
    assign chan1_xfer_done_n = done_n[1];
    assign mem_request_n = !(in_access && state != tcdma_pkg::S_T1
        && cur_mode != tcdma_pkg::AM_IO_FIXED);
    assign io_request_n = !(in_access && state != tcdma_pkg::S_T1
        && cur_mode == tcdma_pkg::AM_IO_FIXED);
    assign rd_n = !(in_access && state != tcdma_pkg::S_T1 && !is_write);
    assign wr_n = !(in_access && state != tcdma_pkg::S_T1 && is_write);

endmodule : tcdma_ctrl

// File: hdl/tcdma_defines.svh
// Constants of the DMA bus control
`ifndef TCDMA_DEFINES_SVH
`define TCDMA_DEFINES_SVH

// Status register layout
`define TCDMA_ST_EN1 7
`define TCDMA_ST_EN0 6
`define TCDMA_ST_GUARD1 5
`define TCDMA_ST_GUARD0 4
`define TCDMA_ST_IE1 3
`define TCDMA_ST_IE0 2
`define TCDMA_ST_MASTER 0
`define TCDMA_ST_RESET 8'h00
`define TCDMA_ST_READ_ONES 8'h32

// Control register layout
`define TCDMA_CT_SENSE1 3
`define TCDMA_CT_SENSE0 2
`define TCDMA_CT_C1_MEM_TO_IO 1
`define TCDMA_CT_C1_MEM_DEC 0
`define TCDMA_CT_RESET 8'h00

// Mode register layout
`define TCDMA_MD_DST_HI 5
`define TCDMA_MD_DST_LO 4
`define TCDMA_MD_SRC_HI 3
`define TCDMA_MD_SRC_LO 2
`define TCDMA_MD_BURST 1
`define TCDMA_MD_RESET 8'h00

// Address slots
`define TCDMA_SLOT_SRC0 2'h0
`define TCDMA_SLOT_DST0 2'h1
`define TCDMA_SLOT_MEM1 2'h2
`define TCDMA_SLOT_IO1 2'h3

// Timing
`define TCDMA_AUTO_IO_WAITS 3'h1
`define TCDMA_CPU_SLOT_NS 30
`define TCDMA_CLK_NS 10
`define TCDMA_LAST_COUNT 16'h0001

`endif

// File: hdl/tcdma_pkg.sv
// Types shared by the DMA bus control
package tcdma_pkg;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_T1 = 3'h1,
        S_T2 = 3'h3,
        S_TW = 3'h2,
        S_T3 = 3'h6,
        S_TI = 3'h7,
        S_HOLD = 3'h4
    } tcdma_state_t;

    typedef enum logic [1:0] {
        AM_MEM_INC = 2'h0,
        AM_MEM_DEC = 2'h1,
        AM_MEM_FIXED = 2'h2,
        AM_IO_FIXED = 2'h3
    } tcdma_amode_t;

endpackage : tcdma_pkg

// File: hdl/tcdma_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module tcdma_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pin side and synchronised side
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1 <= INIT;
            sync_out <= INIT;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : tcdma_sync
